// [nvc_pkg.sv]
/*
 * Shared constants and types for the data nonvolatile byte access controller:
 * register offsets, control bit positions, reset values and write timing.
 * Assumes a 10 MHz system clock and a slow subsystem clock near 32 kHz.
 */
package nvc_pkg;

    // Special function register offsets (sector 0 unless noted)
    localparam logic [7:0] NVC_IND1_OFS = 8'h02;
    localparam logic [7:0] NVC_P1L_OFS = 8'h03;
    localparam logic [7:0] NVC_P1H_OFS = 8'h04;
    localparam logic [7:0] NVC_IND2_OFS = 8'h05;
    localparam logic [7:0] NVC_P2L_OFS = 8'h06;
    localparam logic [7:0] NVC_P2H_OFS = 8'h07;
    localparam logic [7:0] NVC_INDEX_OFS = 8'h2c;
    localparam logic [7:0] NVC_VALUE_OFS = 8'h2d;
    // Control register sits in sector 1 only
    localparam logic [7:0] NVC_CTRL_OFS = 8'h40;
    localparam logic [7:0] NVC_CTRL_SECTOR = 8'h01;

    // Control register bit positions
    localparam int NVC_STORE_PERMIT_BIT = 3;
    localparam int NVC_STORE_GO_BIT = 2;
    localparam int NVC_READ_PERMIT_BIT = 1;
    localparam int NVC_FETCH_GO_BIT = 0;

    localparam int NVC_SMALL_INDEX_BITS = 5;
    localparam int NVC_LARGE_INDEX_BITS = 6;
    localparam int NVC_ARRAY_DEPTH = 64;

    localparam logic [7:0] NVC_REG_RESET = 8'h00;

    // Write timing: slow clock period and write duration in ns
    localparam int NVC_SYS_PERIOD_NS = 100;
    localparam int NVC_SUB_PERIOD_NS = 31250;
    localparam int NVC_WRITE_TIME_NS = 2000000;
    localparam int NVC_SUB_DIV_CYCLES = NVC_SUB_PERIOD_NS / NVC_SYS_PERIOD_NS;
    localparam logic [8:0] NVC_SUB_DIV_LAST = 9'(NVC_SUB_DIV_CYCLES - 1);
    localparam int NVC_WRITE_TICKS = NVC_WRITE_TIME_NS / NVC_SUB_PERIOD_NS;

    typedef enum logic [3:0] {
        NVC_SEL_NONE,
        NVC_SEL_IND1,
        NVC_SEL_IND2,
        NVC_SEL_P1L,
        NVC_SEL_P1H,
        NVC_SEL_P2L,
        NVC_SEL_P2H,
        NVC_SEL_INDEX,
        NVC_SEL_VALUE,
        NVC_SEL_CTRL
    } nvc_sel_type;

    typedef enum logic [1:0] {
        NVC_ST_IDLE,
        NVC_ST_READ,
        NVC_ST_LOAD,
        NVC_ST_WRITE
    } nvc_state_type;

endpackage : nvc_pkg

// [nvc_byte_array.sv]
/*
 * Byte array of the nonvolatile data memory, 64 bytes deep.
 * Assumes the controller issues at most one access per cycle; read data
 * appear registered one cycle after rd_en.
 */
`timescale 1ns/1ps
module nvc_byte_array
    import nvc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic wr_en,
    input wire logic [5:0] wr_index,
    input wire logic [7:0] wr_value,
    input wire logic rd_en,
    input wire logic [5:0] rd_index,
    output logic [7:0] rd_value_q
);
    typedef struct packed {
        logic [NVC_ARRAY_DEPTH-1:0][7:0] cells;
        logic [7:0] rd_value;
    } nvc_array_type;

    nvc_array_type s_q;
    nvc_array_type s_d;

    always_comb begin
        s_d = s_q;
        if (wr_en) begin
            s_d.cells[wr_index] = wr_value;
        end
        if (rd_en) begin
            s_d.rd_value = s_q.cells[rd_index];
        end
    end

    // Contents survive reset, as a nonvolatile store must
    always_ff @(posedge sys_clk) begin
        s_q <= s_d;
        if (!rstn) begin
            s_q.rd_value <= NVC_REG_RESET;
        end
    end

    assign rd_value_q = s_q.rd_value;

endmodule : nvc_byte_array

// [nvc_write_timer.sv]
/*
 * Write cycle timer. A free-running prescaler stands in for the slow
 * subsystem clock, so a write ends a non-cycle-exact time after start.
 * Assumes start is a single-cycle pulse given only while not busy.
 */
`timescale 1ns/1ps
module nvc_write_timer
    import nvc_pkg::*;
#(
    parameter int unsigned WRITE_TICKS = NVC_WRITE_TICKS
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic start,
    output logic done_q
);
    typedef struct packed {
        logic [8:0] prescale;
        logic [9:0] ticks;
        logic busy;
        logic done;
    } nvc_timer_type;

    nvc_timer_type s_q;
    nvc_timer_type s_d;
    logic tick;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        tick = (s_q.prescale == NVC_SUB_DIV_LAST);
        // Prescaler never stops: start phase against it is arbitrary
        s_d.prescale = tick ? 9'h000 : s_q.prescale + 9'h001;
        if (start) begin
            s_d.busy = 1'b1;
            s_d.ticks = 10'h000;
        end else if (s_q.busy && tick) begin
            if (s_q.ticks == 10'(WRITE_TICKS - 1)) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.ticks = s_q.ticks + 10'h001;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done_q = s_q.done;

endmodule : nvc_write_timer

// [nvc_controller.sv]
/*
 * Data nonvolatile byte access controller: index, value and control
 * registers, two memory pointer pairs with indirect ports, read and write
 * sequencing, completion flags. Assumes the processor issues at most one
 * register read or write per cycle on the same clock.
 */
`timescale 1ns/1ps
module nvc_controller
    import nvc_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1,
    parameter int unsigned WRITE_TICKS = NVC_WRITE_TICKS
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic cpu_wr_en,
    input wire logic cpu_rd_en,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata_q,
    input wire logic done_flag_clr,
    input wire logic shared_irq_service,
    output logic nv_done_flag_q,
    output logic shared_irq_flag_q
);
    typedef struct packed {
        nvc_state_type state;
        logic [7:0] index;
        logic [7:0] value;
        logic [7:0] p1l;
        logic [7:0] p1h;
        logic [7:0] p2l;
        logic [7:0] p2h;
        logic store_permit;
        logic store_go;
        logic read_permit;
        logic fetch_go;
        logic [5:0] wr_index;
        logic [7:0] wr_value;
        logic done_flag;
        logic shared_flag;
        logic [7:0] rdata;
    } nvc_regs_type;

    nvc_regs_type s_q;
    nvc_regs_type s_d;
    nvc_sel_type sel;
    logic mem_we;
    logic mem_re;
    logic [7:0] mem_rdata;
    logic timer_start;
    logic timer_done;

    // Map a sector and offset onto a register; control exists only in sector 1
    function automatic nvc_sel_type nvc_decode(input logic [7:0] sector, input logic [7:0] ofs);
        nvc_sel_type r;
        r = NVC_SEL_NONE;
        if (sector == NVC_CTRL_SECTOR) begin
            if (ofs == NVC_CTRL_OFS) begin
                r = NVC_SEL_CTRL;
            end
        end else if (sector == 8'h00) begin
            unique case (ofs)
                NVC_IND1_OFS: r = NVC_SEL_IND1;
                NVC_IND2_OFS: r = NVC_SEL_IND2;
                NVC_P1L_OFS: r = NVC_SEL_P1L;
                NVC_P1H_OFS: r = NVC_SEL_P1H;
                NVC_P2L_OFS: r = NVC_SEL_P2L;
                NVC_P2H_OFS: r = NVC_SEL_P2H;
                NVC_INDEX_OFS: r = NVC_SEL_INDEX;
                NVC_VALUE_OFS: r = NVC_SEL_VALUE;
                default: r = NVC_SEL_NONE;
            endcase
        end
        return r;
    endfunction : nvc_decode

    function automatic logic [7:0] nvc_index_mask(input logic [7:0] v);
        logic [7:0] m;
        m = LARGE_VARIANT ? 8'h3f : 8'h1f;
        return v & m;
    endfunction : nvc_index_mask

    always_comb begin
        nvc_sel_type direct_sel;
        logic [7:0] w;
        direct_sel = nvc_decode(8'h00, cpu_addr);
        w = cpu_wdata;
        // Control is unreachable directly; only an indirect port can land on it
        if (direct_sel == NVC_SEL_IND1) begin
            sel = nvc_decode(s_q.p1h, s_q.p1l);
        end else if (direct_sel == NVC_SEL_IND2) begin
            sel = nvc_decode(s_q.p2h, s_q.p2l);
        end else begin
            sel = direct_sel;
        end
        // Indirect through an indirect port leads nowhere
        if ((direct_sel == NVC_SEL_IND1 || direct_sel == NVC_SEL_IND2)
            && (sel == NVC_SEL_IND1 || sel == NVC_SEL_IND2)) begin
            sel = NVC_SEL_NONE;
        end

        s_d = s_q;
        mem_we = 1'b0;
        mem_re = 1'b0;
        timer_start = 1'b0;

        if (cpu_wr_en) begin
            unique case (sel)
                NVC_SEL_P1L: s_d.p1l = w;
                NVC_SEL_P1H: s_d.p1h = w;
                NVC_SEL_P2L: s_d.p2l = w;
                NVC_SEL_P2H: s_d.p2h = w;
                NVC_SEL_INDEX: s_d.index = nvc_index_mask(w);
                NVC_SEL_VALUE: s_d.value = w;
                NVC_SEL_CTRL: begin
                    s_d.store_permit = w[NVC_STORE_PERMIT_BIT];
                    s_d.read_permit = w[NVC_READ_PERMIT_BIT];
                    // A go bit counts only if its permit was set beforehand,
                    // so setting permit and go in one write starts nothing
                    if (s_q.state == NVC_ST_IDLE) begin
                        if (w[NVC_STORE_GO_BIT] && s_q.store_permit) begin
                            s_d.store_go = 1'b1;
                            s_d.wr_index = s_q.index[5:0];
                            s_d.wr_value = s_q.value;
                            s_d.state = NVC_ST_WRITE;
                            timer_start = 1'b1;
                        end else if (w[NVC_FETCH_GO_BIT] && s_q.read_permit) begin
                            s_d.fetch_go = 1'b1;
                            s_d.state = NVC_ST_READ;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // Clear first so a same-cycle completion still leaves the flag set
        if (done_flag_clr) begin
            s_d.done_flag = 1'b0;
        end
        if (shared_irq_service) begin
            s_d.shared_flag = 1'b0;
        end

        unique case (s_q.state)
            NVC_ST_IDLE: begin
            end
            NVC_ST_READ: begin
                mem_re = 1'b1;
                s_d.state = NVC_ST_LOAD;
            end
            NVC_ST_LOAD: begin
                // Hardware load wins over a software write to the value register
                s_d.value = mem_rdata;
                s_d.fetch_go = 1'b0;
                s_d.state = NVC_ST_IDLE;
            end
            NVC_ST_WRITE: begin
                if (timer_done) begin
                    mem_we = 1'b1;
                    s_d.store_go = 1'b0;
                    s_d.done_flag = 1'b1;
                    s_d.shared_flag = 1'b1;
                    s_d.state = NVC_ST_IDLE;
                end
            end
        endcase

        if (cpu_rd_en) begin
            unique case (sel)
                NVC_SEL_P1L: s_d.rdata = s_q.p1l;
                NVC_SEL_P1H: s_d.rdata = s_q.p1h;
                NVC_SEL_P2L: s_d.rdata = s_q.p2l;
                NVC_SEL_P2H: s_d.rdata = s_q.p2h;
                NVC_SEL_INDEX: s_d.rdata = nvc_index_mask(s_q.index);
                NVC_SEL_VALUE: s_d.rdata = s_q.value;
                NVC_SEL_CTRL: s_d.rdata = {4'h0, s_q.store_permit, s_q.store_go,
                                           s_q.read_permit, s_q.fetch_go};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            // Store permit low and pointers in sector 0 keep writes locked out
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    nvc_byte_array u_array (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .wr_en(mem_we),
        .wr_index(s_q.wr_index),
        .wr_value(s_q.wr_value),
        .rd_en(mem_re),
        .rd_index(s_q.index[5:0]),
        .rd_value_q(mem_rdata)
    );

    nvc_write_timer #(
        .WRITE_TICKS(WRITE_TICKS)
    ) u_timer (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .start(timer_start),
        .done_q(timer_done)
    );

    assign cpu_rdata_q = s_q.rdata;
    assign nv_done_flag_q = s_q.done_flag;
    assign shared_irq_flag_q = s_q.shared_flag;

    default clocking nvc_cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    AST_WRITE_NEEDS_PERMIT: assert property (
        (s_q.state == NVC_ST_IDLE && !s_q.store_permit) |=> s_q.state != NVC_ST_WRITE)
        else $error("write started without store permit");

    AST_READ_NEEDS_PERMIT: assert property (
        (s_q.state == NVC_ST_IDLE && !s_q.read_permit) |=> s_q.state != NVC_ST_READ)
        else $error("read started without read permit");

    AST_READ_SEQUENCE: assert property (
        $rose(s_q.fetch_go) |-> s_q.state == NVC_ST_READ ##1 s_q.state == NVC_ST_LOAD
            ##1 (!s_q.fetch_go && s_q.state == NVC_ST_IDLE))
        else $error("read cycle did not end in two cycles");

    AST_READ_LOADS_VALUE: assert property (
        s_q.state == NVC_ST_LOAD |=> s_q.value == $past(mem_rdata))
        else $error("read byte not placed in value register");

    AST_INDEX_UPPER_ZERO: assert property (
        LARGE_VARIANT ? (s_q.index[7:6] == 2'b00) : (s_q.index[7:5] == 3'b000))
        else $error("unimplemented index bits not zero");

    AST_WRITE_END: assert property (
        (s_q.state == NVC_ST_WRITE && timer_done)
            |=> (!s_q.store_go && s_q.done_flag && s_q.shared_flag && s_q.state == NVC_ST_IDLE))
        else $error("write end did not clear go and raise flags");

    // The array write lands in the done cycle itself, so the next cycle only holds state and go
    AST_WRITE_HOLDS_TILL_TIMER: assert property (
        (s_q.state == NVC_ST_WRITE && !timer_done)
            |=> (s_q.state == NVC_ST_WRITE && s_q.store_go && !s_q.fetch_go))
        else $error("write ended before timer");

    AST_NO_EARLY_STORE: assert property (
        !timer_done |-> !mem_we)
        else $error("array written before the timer ended");

    AST_DONE_STICKY: assert property (
        (s_q.done_flag && !done_flag_clr) |=> s_q.done_flag)
        else $error("done flag lost without software clear");

    AST_RESET_LOCKS: assert property (
        $rose(rstn) |-> (!s_q.store_permit && s_q.p1h == 8'h00 && s_q.p2h == 8'h00))
        else $error("reset left writes reachable");

endmodule : nvc_controller

// [nvc_cpu_model.sv]
/*
 * Software-side model of the processor's register accesses: byte writes,
 * byte reads, control access through a pointer pair and cycle starts.
 * Assumes the controller takes one strobe per sys_clk edge.
 */
`timescale 1ns/1ps
module nvc_cpu_model
    import nvc_pkg::*;
(
    input wire logic sys_clk,
    output logic cpu_wr_en,
    output logic cpu_rd_en,
    output logic [7:0] cpu_addr,
    output logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata_q
);
    logic [7:0] ind_ofs;

    initial begin
        cpu_wr_en = 1'b0;
        cpu_rd_en = 1'b0;
        cpu_addr = 8'h00;
        cpu_wdata = 8'h00;
        ind_ofs = NVC_IND1_OFS;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_wr_en <= 1'b1;
        cpu_addr <= a;
        cpu_wdata <= d;
        @(posedge sys_clk);
        cpu_wr_en <= 1'b0;
        // Released bus must not keep showing the last byte
        cpu_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        cpu_rd_en <= 1'b1;
        cpu_addr <= a;
        @(posedge sys_clk);
        cpu_rd_en <= 1'b0;
        cpu_addr <= ~a;
        @(posedge sys_clk);
        d = cpu_rdata_q;
    endtask : rd

    // Control lives at 40h of sector 1, reached only through a pointer pair
    task automatic set_ptr(input logic second);
        ind_ofs = second ? NVC_IND2_OFS : NVC_IND1_OFS;
        wr(second ? NVC_P2L_OFS : NVC_P1L_OFS, NVC_CTRL_OFS);
        wr(second ? NVC_P2H_OFS : NVC_P1H_OFS, NVC_CTRL_SECTOR);
    endtask : set_ptr

    // Permit, then go in the very next cycle, never both go bits together
    // Strobe stays up across the pair, so nothing can slip in between
    task automatic start(input logic store);
        @(posedge sys_clk);
        cpu_wr_en <= 1'b1;
        cpu_addr <= ind_ofs;
        cpu_wdata <= store ? 8'h08 : 8'h02;
        @(posedge sys_clk);
        cpu_wdata <= store ? 8'h0c : 8'h03;
        @(posedge sys_clk);
        cpu_wr_en <= 1'b0;
        cpu_wdata <= store ? 8'hf3 : 8'hfc;
    endtask : start

    // Control is left alone until the running cycle drops its go bit; no idling meanwhile
    task automatic poll(input int bit_no, input int limit, output logic ok);
        logic [7:0] d;
        ok = 1'b0;
        for (int i = 0; i < limit && !ok; i++) begin
            rd(ind_ofs, d);
            ok = (d[bit_no] === 1'b0);
        end
    endtask : poll
endmodule : nvc_cpu_model

// [nvc_controller_tb_top.sv]
/*
 * Self-checking bench for the nonvolatile byte access controller: reset
 * values, index width, permit gating, write and read cycles, flags.
 * Assumes nvc_cpu_model drives the register strobes on sys_clk.
 */
`timescale 1ns/1ps
module nvc_controller_tb_top
    import nvc_pkg::*;
;
    // Two prescaler ticks keep each write at most 624 cycles long
    localparam int unsigned TICKS = 2;
    logic sys_clk, rstn, cpu_wr_en, cpu_rd_en, done_flag_clr, shared_irq_service;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata_q, d;
    logic nv_done_flag_q, shared_irq_flag_q, ok;
    logic taken = 1'b0;
    logic want_rd = 1'b0;
    logic [7:0] exp_q[$];
    logic [5:0] idx[4];
    logic [7:0] val[4];
    int num_errors = 0;
    int n_tests = 0;
    int seed = 87847;

    nvc_controller #(.LARGE_VARIANT(1'b1), .WRITE_TICKS(TICKS)) nvc_controller_inst (
        .sys_clk(sys_clk), .rstn(rstn), .cpu_wr_en(cpu_wr_en), .cpu_rd_en(cpu_rd_en),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q),
        .done_flag_clr(done_flag_clr), .shared_irq_service(shared_irq_service),
        .nv_done_flag_q(nv_done_flag_q), .shared_irq_flag_q(shared_irq_flag_q)
    );

    nvc_cpu_model nvc_cpu_model_inst (
        .sys_clk(sys_clk), .cpu_wr_en(cpu_wr_en), .cpu_rd_en(cpu_rd_en),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata_q(cpu_rdata_q)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        nvc_cpu_model_inst.wr(a, v);
    endtask : wr

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        want_rd = 1'b1;
        nvc_cpu_model_inst.rd(a, d);
        want_rd = 1'b0;
    endtask : chk_rd

    task automatic chk_flags(input logic done, input logic shared);
        chk({6'h00, nv_done_flag_q, shared_irq_flag_q}, {6'h00, done, shared});
    endtask : chk_flags

    task automatic pulse(input logic svc);
        @(posedge sys_clk);
        shared_irq_service <= svc;
        done_flag_clr <= !svc;
        @(posedge sys_clk);
        shared_irq_service <= 1'b0;
        done_flag_clr <= 1'b0;
        @(posedge sys_clk);
    endtask : pulse

    task automatic wait_go(input int b, input int lim);
        nvc_cpu_model_inst.poll(b, lim, ok);
        chk({7'h00, ok}, 8'h01);
        if (!ok) begin
            final_report;
        end
    endtask : wait_go

    // Read data is due one edge after the strobe was taken; polling reads carry no note
    always @(posedge sys_clk) begin
        if (taken && exp_q.size() > 0) begin
            chk(cpu_rdata_q, exp_q.pop_front());
        end
        taken <= rstn && cpu_rd_en && want_rd;
    end

    initial begin
        rstn = 1'b0;
        done_flag_clr = 1'b0;
        shared_irq_service = 1'b0;
        repeat (6) @(posedge sys_clk);
        rstn <= 1'b1;
        chk_rd(NVC_INDEX_OFS, NVC_REG_RESET);
        chk_rd(NVC_VALUE_OFS, NVC_REG_RESET);
        chk_rd(NVC_P1H_OFS, 8'h00);
        chk_rd(NVC_P2H_OFS, 8'h00);
        chk_rd(NVC_CTRL_OFS, 8'h00);
        nvc_cpu_model_inst.set_ptr(1'b0);
        chk_rd(NVC_IND1_OFS, NVC_REG_RESET);
        wr(NVC_INDEX_OFS, 8'hff);
        chk_rd(NVC_INDEX_OFS, 8'h3f);
        wr(NVC_IND1_OFS, 8'h01);
        chk_rd(NVC_IND1_OFS, 8'h00);
        wr(NVC_IND1_OFS, 8'h04);
        chk_rd(NVC_IND1_OFS, 8'h00);
        chk_flags(1'b0, 1'b0);
        // Permit and go in one write sets the permit only
        wr(NVC_IND1_OFS, 8'h0c);
        chk_rd(NVC_IND1_OFS, 8'h08);
        wr(NVC_IND1_OFS, 8'h00);
        wr(NVC_IND1_OFS, 8'h03);
        chk_rd(NVC_IND1_OFS, 8'h02);
        wr(NVC_IND1_OFS, 8'h00);
        // The slow clock stand-in runs from reset; give it a full period first
        repeat (NVC_SUB_DIV_CYCLES) @(posedge sys_clk);
        for (int i = 0; i < 4; i++) begin
            idx[i] = {i[1:0], (i == 3) ? 4'hf : 4'($random(seed))};
            val[i] = 8'($random(seed));
            wr(NVC_INDEX_OFS, {2'b00, idx[i]});
            wr(NVC_VALUE_OFS, val[i]);
            nvc_cpu_model_inst.start(1'b1);
            chk_rd(NVC_IND1_OFS, 8'h0c);
            wait_go(2, 400);
            chk_flags(1'b1, 1'b1);
            pulse(1'b1);
            chk_flags(1'b1, 1'b0);
            pulse(1'b0);
            chk_flags(1'b0, 1'b0);
            wr(NVC_IND1_OFS, 8'h00);
        end
        // Go without store permit; wait past a full write time before reading back
        wr(NVC_INDEX_OFS, {2'b00, idx[0]});
        wr(NVC_VALUE_OFS, ~val[0]);
        wr(NVC_IND1_OFS, 8'h04);
        repeat (700) @(posedge sys_clk);
        chk_flags(1'b0, 1'b0);
        for (int i = 0; i < 4; i++) begin
            nvc_cpu_model_inst.set_ptr(i[0]);
            wr(NVC_INDEX_OFS, {2'b00, idx[i]});
            wr(NVC_VALUE_OFS, ~val[i]);
            nvc_cpu_model_inst.start(1'b0);
            wait_go(0, 20);
            chk_rd(NVC_VALUE_OFS, val[i]);
            chk_rd(NVC_VALUE_OFS, val[i]);
            wr(nvc_cpu_model_inst.ind_ofs, 8'h00);
        end
        // Mid-run reset: permits and pointers clear, array contents survive
        wr(nvc_cpu_model_inst.ind_ofs, 8'h08);
        chk_rd(NVC_CTRL_OFS, 8'h00);
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        chk_rd(NVC_P2H_OFS, 8'h00);
        nvc_cpu_model_inst.set_ptr(1'b1);
        chk_rd(NVC_IND2_OFS, NVC_REG_RESET);
        wr(NVC_INDEX_OFS, {2'b00, idx[3]});
        nvc_cpu_model_inst.start(1'b0);
        wait_go(0, 20);
        chk_rd(NVC_VALUE_OFS, val[3]);
        final_report;
    end
endmodule : nvc_controller_tb_top
